// ==== src/result_reset_carrier_cmds.sv ====
`timescale 1ns/1ps
`include "cmd_defines.svh"

// Operation
// R1: Result set 0 or no argument enables codes 0-4, no busy code and no connect speed.
// R2: Result set 1 or 2 enables codes 0-5, 10-12 and 14, no busy code, speed with connect.
// R3: Result set 3 or 4 adds code 7, sends busy on a busy line and gives speed with connect.
// R4: The result-set command writes its argument into bits 4 to 6 of the result option store.
// R5: Every call outcome waits for call completion or expiry of the call wait timer.
// R6: Recall with no argument or 0 picks profile 0, and argument 1 picks profile 1.
// R7: Recall first resets and then copies the chosen profile into the active settings.
// R8: Carrier option 0 or no argument keeps the carrier-detect output on at all times outside self-test.
// R9: Carrier option 1 makes carrier-detect follow the real carrier state.
// R10: The carrier option command sets bit 5 of the line option store.
// R11: Carrier-detect is forced off during self-test whatever option is chosen.
// R12: An argument out of range leaves storage unchanged and returns an error result.
module result_reset_carrier_cmds (
    // Clock and reset
    input  wire logic                 SYS_CLK,
    input  wire logic                 RST_N,
    // Avalon-MM slave
    input  wire logic [4:0]           AVS_ADDRESS,
    input  wire logic                 AVS_READ,
    input  wire logic                 AVS_WRITE,
    input  wire logic [31:0]          AVS_WRITEDATA,
    output logic      [31:0]          AVS_READDATA,
    output logic                      AVS_WAITREQUEST,
    // Line side pins
    input  wire logic                 CARRIER_IN,
    input  wire logic                 CALL_DONE_IN,
    input  wire logic                 SELF_TEST_IN,
    output logic                      DCD_OUT,
    output logic                      MODULE_RESET,
    // Result reporting
    output cmd_pkg::result_s          RESULT,
    output logic                      RESULT_VALID
);

    typedef struct packed {
        cmd_pkg::state_e    state;
        cmd_pkg::profile_s  active;
        cmd_pkg::profile_s  prof0;
        cmd_pkg::profile_s  prof1;
        logic [7:0]         wait_tmr;
        logic [3:0]         rst_cnt;
        logic [31:0]        tick_cnt;
        logic [7:0]         sec_cnt;
        logic               sel1;
        logic [1:0]         sync_car;
        logic [1:0]         sync_done;
        logic [1:0]         sync_test;
        cmd_pkg::result_s   result;
        logic               result_valid;
        logic               ack;
        logic [31:0]        rdata;
        logic               dcd;
    } state_s;

    state_s s_q;
    state_s s_d;

    cmd_pkg::code_mask_t code_mask;
    logic                busy_en;
    logic                speed_en;

    // Sync stages: bit 0 is first flop, bit 1 second; only bit 1 feeds logic
    logic car_s;
    logic done_s;
    logic test_s;
    assign car_s  = s_q.sync_car[1];
    assign done_s = s_q.sync_done[1];
    assign test_s = s_q.sync_test[1];

    result_filter u_filter (
        .rset      (s_q.active.result_sr[`RSET_LSB +: 3]),
        .code_mask (code_mask),
        .busy_en   (busy_en),
        .speed_en  (speed_en)
    );

    logic       wr;
    logic       rd;
    logic [1:0] op;
    logic [2:0] arg;
    logic       noarg;

    assign wr    = AVS_WRITE && !s_q.ack;
    assign rd    = AVS_READ && !s_q.ack;
    assign op    = AVS_WRITEDATA[`CMD_OP_LSB +: 2];
    assign arg   = AVS_WRITEDATA[`CMD_ARG_LSB +: 3];
    assign noarg = AVS_WRITEDATA[`CMD_NOARG_BIT];

    always_comb begin
        s_d = s_q;
        s_d.sync_car  = {s_q.sync_car[0], CARRIER_IN};
        s_d.sync_done = {s_q.sync_done[0], CALL_DONE_IN};
        s_d.sync_test = {s_q.sync_test[0], SELF_TEST_IN};
        s_d.ack          = 1'b0;
        s_d.result_valid = 1'b0;

        // Bus access is held off while the recall sequence owns the settings
        if ((wr || rd) && s_q.state != cmd_pkg::ST_RESET && s_q.state != cmd_pkg::ST_COPY) begin
            s_d.ack   = 1'b1;
            s_d.rdata = 32'h0;
            if (rd) begin
                if (AVS_ADDRESS == {1'b0, `ADDR_STATUS}) begin
                    s_d.rdata = {13'h0, s_q.dcd, busy_en, speed_en, code_mask};
                end else if (AVS_ADDRESS == {1'b0, `ADDR_RESULT_SR}) begin
                    s_d.rdata = {24'h0, s_q.active.result_sr};
                end else if (AVS_ADDRESS == {1'b0, `ADDR_LINE_SR}) begin
                    s_d.rdata = {24'h0, s_q.active.line_sr};
                end else if (AVS_ADDRESS == `ADDR_TMR) begin
                    s_d.rdata = {24'h0, s_q.wait_tmr};
                end else if (AVS_ADDRESS == `ADDR_PROF0_R) begin
                    s_d.rdata = {16'h0, s_q.prof0};
                end else if (AVS_ADDRESS == `ADDR_PROF1_R) begin
                    s_d.rdata = {16'h0, s_q.prof1};
                end else if (AVS_ADDRESS == `ADDR_IDLE) begin
                    s_d.rdata = {29'h0, s_q.state};
                end
            end else if (AVS_ADDRESS == `ADDR_TMR) begin
                s_d.wait_tmr = AVS_WRITEDATA[7:0];
            end else if (AVS_ADDRESS == `ADDR_PROF0_R) begin
                s_d.prof0 = AVS_WRITEDATA[15:0];
            end else if (AVS_ADDRESS == `ADDR_PROF1_R) begin
                s_d.prof1 = AVS_WRITEDATA[15:0];
            end else if (AVS_ADDRESS == {1'b0, `ADDR_CMD}) begin
                s_d.result = '0;
                s_d.result_valid = 1'b1;
                case (cmd_pkg::op_e'(op))
                    cmd_pkg::OP_RESULT_SET: begin
                        if (!noarg && arg > `RSET_MAX) begin
                            s_d.result.err = 1'b1;                                  // R12
                        end else begin
                            s_d.active.result_sr[`RSET_LSB +: 3] = noarg ? 3'h0 : arg; // R4
                            s_d.result.ok = 1'b1;
                        end
                    end
                    cmd_pkg::OP_CARRIER: begin
                        if (!noarg && arg > `CDOPT_MAX) begin
                            s_d.result.err = 1'b1;                                  // R12
                        end else begin
                            s_d.active.line_sr[`DCD_BIT] = noarg ? 1'b0 : arg[0];   // R10
                            s_d.result.ok = 1'b1;
                        end
                    end
                    cmd_pkg::OP_RECALL: begin
                        if (!noarg && arg > `PROF_MAX) begin
                            s_d.result.err = 1'b1;                                  // R12
                        end else begin
                            s_d.sel1         = noarg ? 1'b0 : arg[0];               // R6
                            s_d.rst_cnt      = `RESET_CYCLES;
                            s_d.state        = cmd_pkg::ST_RESET;                   // R7
                            s_d.result_valid = 1'b0;
                        end
                    end
                    default: begin
                        // Starts call progress reporting
                        s_d.tick_cnt     = 32'h0;
                        s_d.sec_cnt      = 8'h0;
                        s_d.state        = cmd_pkg::ST_CALL;
                        s_d.result_valid = 1'b0;
                    end
                endcase
            end
        end

        case (s_q.state)
            cmd_pkg::ST_RESET: begin
                s_d.rst_cnt = s_q.rst_cnt - 4'h1;
                if (s_q.rst_cnt == 4'h1) begin
                    s_d.active = '0;                                                // R7
                    s_d.state  = cmd_pkg::ST_COPY;
                end
            end
            cmd_pkg::ST_COPY: begin
                s_d.active       = s_q.sel1 ? s_q.prof1 : s_q.prof0;               // R6 R7
                s_d.result       = '0;
                s_d.result.ok    = 1'b1;
                s_d.result_valid = 1'b1;
                s_d.state        = cmd_pkg::ST_IDLE;
            end
            cmd_pkg::ST_CALL: begin
                // Outcome waits for completion or timer expiry in whole seconds
                if (s_q.tick_cnt == `TICKS_PER_SEC - 32'h1) begin
                    s_d.tick_cnt = 32'h0;
                    s_d.sec_cnt  = s_q.sec_cnt + 8'h1;
                end else begin
                    s_d.tick_cnt = s_q.tick_cnt + 32'h1;
                end
                if (done_s || s_q.sec_cnt >= s_q.wait_tmr) begin                   // R5
                    s_d.result         = '0;
                    s_d.result.ok      = done_s;
                    s_d.result.busy_ok = busy_en;
                    s_d.result.speed   = speed_en;
                    s_d.result.code    = done_s ? 4'h1 : 4'h3;
                    s_d.result_valid   = 1'b1;
                    s_d.state          = cmd_pkg::ST_IDLE;
                end
            end
            default: begin
            end
        endcase

        if (test_s) begin
            s_d.dcd = 1'b0;                                                         // R11
        end else if (s_q.active.line_sr[`DCD_BIT]) begin
            s_d.dcd = car_s;                                                        // R9
        end else begin
            s_d.dcd = 1'b1;                                                         // R8
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q          <= '0;
            s_q.wait_tmr <= `WAIT_TMR_RST;
            s_q.state    <= cmd_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !s_q.ack;
    assign AVS_READDATA    = s_q.rdata;
    assign DCD_OUT         = s_q.dcd;
    assign MODULE_RESET    = (s_q.state == cmd_pkg::ST_RESET);
    assign RESULT          = s_q.result;
    assign RESULT_VALID    = s_q.result_valid;

endmodule : result_reset_carrier_cmds

// ==== common/cmd_defines.svh ====
`ifndef CMD_DEFINES_SVH
`define CMD_DEFINES_SVH

// Register map, word-aligned byte addresses
`define ADDR_CMD        4'h0
`define ADDR_STATUS     4'h4
`define ADDR_RESULT_SR  4'h8
`define ADDR_LINE_SR    4'hc
`define ADDR_WAIT_TMR   4'h0
`define ADDR_PROF0      4'h0
// Extended window for call wait timer, profiles and state readback
`define ADDR_TMR        5'h10
`define ADDR_PROF0_R    5'h14
`define ADDR_PROF1_R    5'h18
`define ADDR_IDLE       5'h1c

// Command register fields
`define CMD_OP_LSB      0
`define CMD_ARG_LSB     4
`define CMD_NOARG_BIT   8

// Storage register fields
`define RSET_LSB        4
`define DCD_BIT         5

// Reset values
`define RESULT_SR_RST   8'h00
`define LINE_SR_RST     8'h00
`define WAIT_TMR_RST    8'h1e

// Argument limits
`define RSET_MAX        3'h4
`define CDOPT_MAX       3'h1
`define PROF_MAX        3'h1

// One second of call wait in 10 ns cycles
`define TICKS_PER_SEC   32'd100000000

// Reset pulse length of the recall sequence
`define RESET_CYCLES    4'h8

`endif

// ==== common/cmd_pkg.sv ====
package cmd_pkg;

    typedef enum logic [1:0] {
        OP_RESULT_SET = 2'h0,
        OP_RECALL     = 2'h1,
        OP_CARRIER    = 2'h2,
        OP_NONE       = 2'h3
    } op_e;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_RESET  = 3'h1,
        ST_COPY   = 3'h3,
        ST_CALL   = 3'h2,
        ST_REPORT = 3'h6
    } state_e;

    typedef struct packed {
        logic       ok;
        logic       err;
        logic       busy_ok;
        logic       speed;
        logic [3:0] code;
    } result_s;

    typedef struct packed {
        logic [7:0] result_sr;
        logic [7:0] line_sr;
    } profile_s;

    typedef logic [15:0] code_mask_t;

endpackage : cmd_pkg

// ==== src/result_filter.sv ====
`timescale 1ns/1ps
`include "cmd_defines.svh"

// Maps the selected result set to enabled codes, busy and speed options
module result_filter (
    // Selection
    input  wire logic [2:0]          rset,
    // Outcome
    output cmd_pkg::code_mask_t      code_mask,
    output logic                     busy_en,
    output logic                     speed_en
);

    always_comb begin
        code_mask = 16'h001f;                       // R1
        busy_en   = 1'b0;
        speed_en  = 1'b0;
        if (rset == 3'h1 || rset == 3'h2) begin
            code_mask = 16'h5c3f;                   // R2
            speed_en  = 1'b1;
        end else if (rset == 3'h3 || rset == 3'h4) begin
            code_mask = 16'h5cbf;                   // R3
            busy_en   = 1'b1;
            speed_en  = 1'b1;
        end
    end

endmodule : result_filter

// ==== test/cmd_chk.sv ====
`timescale 1ns/1ps
module cmd_chk (
    // Clock and reset
    input wire logic             SYS_CLK,
    input wire logic             RST_N,
    // Bus
    input wire logic [4:0]       AVS_ADDRESS,
    input wire logic             AVS_READ,
    input wire logic             AVS_WRITE,
    input wire logic [31:0]      AVS_WRITEDATA,
    input wire logic             AVS_WAITREQUEST,
    // Line and result
    input wire logic             SELF_TEST_IN,
    input wire logic             DCD_OUT,
    input wire logic             MODULE_RESET,
    input wire cmd_pkg::result_s RESULT,
    input wire logic             RESULT_VALID
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    logic set;
    logic bad;
    // Result-set and carrier commands always answer at once; valid recall and call wait take longer
    assign set = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 5'h00 && !AVS_WRITEDATA[0];
    assign bad = !AVS_WRITEDATA[8] && AVS_WRITEDATA[6:4] > (AVS_WRITEDATA[1] ? 3'h1 : 3'h4);
    sequence s_pulse;
        RESULT_VALID ##1 !RESULT_VALID;
    endsequence
    sequence s_reset8;
        MODULE_RESET [*8] ##1 !MODULE_RESET;
    endsequence
    a_bus_answer: assert property ((AVS_READ || AVS_WRITE) |-> ##[0:16] !AVS_WAITREQUEST)
        else $error("bus request not answered");
    // The recall command itself completes in the first reset cycle
    a_recall_stall: assert property (MODULE_RESET && $past(MODULE_RESET) && (AVS_READ || AVS_WRITE)
        |-> AVS_WAITREQUEST)
        else $error("bus answered during recall reset");
    a_reset_len: assert property ($rose(MODULE_RESET) |-> s_reset8)
        else $error("recall reset phase not 8 cycles");
    a_copy_follows: assert property ($fell(MODULE_RESET) |-> ##[0:2] s_pulse)
        else $error("no copy result after reset phase");
    a_selftest_off: assert property (SELF_TEST_IN [*4] |-> !DCD_OUT)
        else $error("carrier detect on during self-test");
    // The result pulse stands in the same cycle as the completing bus beat
    a_cmd_answer: assert property (set |-> s_pulse)
        else $error("command gave no result pulse");
    a_bad_err: assert property (set && bad |-> (RESULT_VALID && RESULT.err))
        else $error("bad argument without error result");
    a_good_ok: assert property (set && !bad |-> (RESULT_VALID && !RESULT.err))
        else $error("good argument gave error result");
endmodule : cmd_chk

// ==== test/term_model.sv ====
`timescale 1ns/1ps
// Terminal side of the command path: one bus access at a time
module term_model (
    // Clock
    input wire logic        clk,
    // Bus
    output logic [4:0]      adr,
    output logic            rd_en,
    output logic            wr_en,
    output logic [31:0]     wdat,
    input wire logic [31:0] rdat,
    input wire logic        wreq
);
    initial begin
        adr = 5'h00;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdat = 32'h0;
    end
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr_en <= w;
        rd_en <= !w;
        // Waitrequest is sampled on the rising edge that completes the transfer
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        wdat <= ~d;
    endtask : xfer
endmodule : term_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic             clk;
    logic             rst_n;
    logic [4:0]       adr;
    logic             rd_en;
    logic             wr_en;
    logic [31:0]      wdat;
    logic [31:0]      rdat;
    logic             wreq;
    logic             carrier;
    logic             call_done;
    logic             stest;
    logic             dcd;
    cmd_pkg::result_s res;
    logic             res_v;
    logic [31:0]      seed;
    logic [31:0]      q;
    int               err_count;
    int               checks_done;
    int               cyc;
    int               nres;
    int               rs;
    int               sel;

    result_reset_carrier_cmds dut (.SYS_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr),
        .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .CARRIER_IN(carrier), .CALL_DONE_IN(call_done),
        .SELF_TEST_IN(stest), .DCD_OUT(dcd), .MODULE_RESET(), .RESULT(res),
        .RESULT_VALID(res_v));
    term_model term (.clk(clk), .adr(adr), .rd_en(rd_en), .wr_en(wr_en), .wdat(wdat),
        .rdat(rdat), .wreq(wreq));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] stat(input int s);
        logic [15:0] m;
        m = (s == 0) ? 16'h001f : (s < 3) ? 16'h5c3f : 16'h5cbf;
        return {13'h0, 1'b1, s > 2, s > 0, m};
    endfunction : stat
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        term.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rc(input string n, input logic [4:0] a, input logic [31:0] e);
        term.xfer(1'b0, a, 32'h0, q);
        chk(n, q, e);
    endtask : rc
    // Covers the two-flop input sync and the output register
    task automatic dcd_is(input logic e);
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk("dcd", {31'h0, dcd}, {31'h0, e});
    endtask : dcd_is
    task automatic wres;
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (res_v !== 1'b1 && n < 60);
        if (res_v !== 1'b1) begin
            err_count++;
            $display("ERROR result expected pulse seen none");
        end
    endtask : wres
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (res_v === 1'b1)
            nres <= nres + 1;
        if (cyc == 6000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        rst_n = 1'b0;
        carrier = 1'b0;
        call_done = 1'b0;
        stest = 1'b0;
        seed = 32'h8e8f;
        rs = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        dcd_is(1'b1);
        rc("timer", 5'h10, 32'h1e);
        rc("hole", 5'h02, 32'h0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            sel = (i < 5) ? i : (i < 7) ? 5 + seed % 3 : 0;
            wr(5'h00, (i == 7) ? 32'h100 : sel << 4);
            if (sel < 5)
                rs = sel;
            rc("status", 5'h04, stat(rs));
            rc("result_sr", 5'h08, rs << 4);
        end
        wr(5'h00, 32'h12);
        rc("line_sr", 5'h0c, 32'h20);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            @(posedge clk);
            carrier <= seed[0];
            dcd_is(seed[0]);
        end
        @(posedge clk);
        carrier <= 1'b1;
        stest <= 1'b1;
        dcd_is(1'b0);
        @(posedge clk);
        carrier <= 1'b0;
        stest <= 1'b0;
        wr(5'h00, 32'h32);
        rc("line_sr", 5'h0c, 32'h20);
        wr(5'h00, 32'h102);
        rc("line_sr", 5'h0c, 32'h0);
        dcd_is(1'b1);
        @(posedge clk);
        stest <= 1'b1;
        dcd_is(1'b0);
        @(posedge clk);
        stest <= 1'b0;
        wr(5'h14, 32'h1000);
        wr(5'h18, 32'h3020);
        wr(5'h00, 32'h11);
        rc("result_sr", 5'h08, 32'h30);
        rc("line_sr", 5'h0c, 32'h20);
        wr(5'h00, 32'h101);
        rc("result_sr", 5'h08, 32'h10);
        rc("line_sr", 5'h0c, 32'h0);
        rc("prof1", 5'h18, 32'h3020);
        rc("state", 5'h1c, 32'h0);
        wr(5'h10, 32'h0);
        wr(5'h00, 32'h3);
        wres();
        chk("result", {24'h0, res}, 32'h13);
        wr(5'h10, 32'h5);
        wr(5'h00, 32'h3);
        sel = nres;
        repeat (20) @(posedge clk);
        chk("early", nres, sel);
        call_done <= 1'b1;
        wres();
        chk("result", {24'h0, res}, 32'h91);
        print_verdict();
    end
endmodule : tb_top

bind result_reset_carrier_cmds cmd_chk chk_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .SELF_TEST_IN(SELF_TEST_IN), .DCD_OUT(DCD_OUT), .MODULE_RESET(MODULE_RESET),
    .RESULT(RESULT), .RESULT_VALID(RESULT_VALID));
